// ==== hdl/sima_regs.svh ====
/*
 * Register offsets, field positions and reset values of the sensor
 * interrupt motor action block. Included by the package and the design.
 */
`ifndef SIMA_REGS_SVH
`define SIMA_REGS_SVH

`define SIMA_ACT_OFFSET 8'h08
`define SIMA_STAT_OFFSET 8'h06
`define SIMA_ACT_RESET 8'h00
`define SIMA_ACT_EN_BIT 0
`define SIMA_ACT_CLR_LSB 3
`define SIMA_ACT_CODE_LSB 5
`define SIMA_ACT_WMASK 8'hf9
`define SIMA_STAT_RESET 4'h0

`endif

// ==== hdl/sima_pkg.sv ====
/*
 * Types of the sensor interrupt motor action block.
 * Assumes the register header is on the include path.
 */
`include "sima_regs.svh"

package sima_pkg;

    typedef enum logic [2:0] {
        SIMA_ACT_STOP_Z = 3'b000,
        SIMA_ACT_STOP_O = 3'b001,
        SIMA_ACT_STOP_E = 3'b010,
        SIMA_ACT_REV_E = 3'b011,
        SIMA_ACT_RST_Z = 3'b100,
        SIMA_ACT_RST_O = 3'b101,
        SIMA_ACT_RST_E = 3'b110,
        SIMA_ACT_RST_E2 = 3'b111
    } sima_code_t;

    // Requests to the motor sequencer outside this block
    typedef struct packed {
        logic stop_req;
        logic reverse_req;
        logic restart_req;
        logic [7:0] overdrive_steps;
    } sima_cmd_t;

    // Register access strobe group from the serial bus slave
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sima_bus_t;

endpackage

// ==== hdl/sima_edge.sv ====
/*
 * Two-flop synchroniser and selectable edge detector for one sensor pin.
 * Assumes an asynchronous pin on the input and one system clock.
 */
`timescale 1ns/1ps

module sima_edge
    import sima_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic pin_in,
    input wire logic falling_in,
    output logic edge_out
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
            edge_out <= 1'b0;
        end
        else
        begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
            edge_out <= falling_in ? (last_reg & ~sync_reg)
                                   : (~last_reg & sync_reg);
        end
    end
endmodule

// ==== hdl/sima_core.sv ====
/*
 * Sensor interrupt driven motor action logic: action register, latched
 * sensor flags, auto-clear and stop, reverse or restart requests.
 * Assumes a serial bus slave delivering one-cycle register strobes and
 * an outside sequencer that runs overdrive, ramps and pauses.
 */
`timescale 1ns/1ps

`include "sima_regs.svh"

module sima_core
    import sima_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire sima_bus_t bus_in,
    input wire logic [3:0] sensor_pin_in,
    input wire logic [3:0] irq_edge_select_in,
    input wire logic [3:0] irq_mask_reg_in,
    input wire logic motor_running_in,
    input wire logic ramping_in,
    input wire logic [7:0] overdrive_count_zero_in,
    input wire logic [7:0] overdrive_count_one_in,
    output logic [7:0] rdata_out,
    output logic [3:0] irq_status_out,
    output sima_cmd_t cmd_out
);
    logic [7:0] sensor_irq_motor_action_reg;
    logic [3:0] irq_status_reg;
    logic [3:0] edge_w;
    logic [3:0] new_w;
    logic stop_seen_reg;
    logic run_last_reg;
    logic enable_w;
    logic take_w;
    logic use0_w;
    logic use1_w;
    logic act0_w;
    logic act1_w;
    logic clr0_w;
    logic clr1_w;
    logic stat_rd_w;
    sima_code_t code_w;

    // ------------------------------------------------------------
    // Input edge detection
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_edge
            sima_edge u_edge (
                .sys_clk_in(sys_clk_in),
                .reset_in(reset_in),
                .pin_in(sensor_pin_in[gi]),
                .falling_in(irq_edge_select_in[gi]),
                .edge_out(edge_w[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Action decode
    // ------------------------------------------------------------
    function automatic logic uses_zero(input sima_code_t c);
        uses_zero = (c != SIMA_ACT_STOP_O) && (c != SIMA_ACT_RST_O);
    endfunction

    function automatic logic uses_one(input sima_code_t c);
        uses_one = (c != SIMA_ACT_STOP_Z) && (c != SIMA_ACT_RST_Z);
    endfunction

    assign code_w = sima_code_t'(
        sensor_irq_motor_action_reg[7:`SIMA_ACT_CODE_LSB]);
    assign enable_w = sensor_irq_motor_action_reg[`SIMA_ACT_EN_BIT];
    assign use0_w = uses_zero(code_w);
    assign use1_w = uses_one(code_w);
    // Latched flags mask repeat edges; mask bits gate latching
    assign new_w = edge_w & ~irq_mask_reg_in & ~irq_status_reg;
    // Either-code collisions: input zero takes priority
    assign take_w = enable_w && !ramping_in
        && motor_running_in;
    assign act0_w = take_w && new_w[0] && use0_w;
    assign act1_w = take_w && new_w[1] && use1_w && !act0_w;
    assign stat_rd_w = (bus_in.rd || bus_in.wr)
        && bus_in.addr == `SIMA_STAT_OFFSET;

    // A partner's new edge clears only a flag that the code uses; the
    // partner itself may be unused, so its edge and not its action counts
    always_comb
    begin
        unique case (sensor_irq_motor_action_reg[4:`SIMA_ACT_CLR_LSB])
            2'b01:
            begin
                clr1_w = take_w && new_w[0] && use1_w;
                clr0_w = take_w && new_w[1] && use0_w;
            end
            2'b10:
            begin
                clr1_w = 1'b0;
                clr0_w = take_w && new_w[1] && use0_w;
            end
            2'b11:
            begin
                clr1_w = take_w && new_w[0] && use1_w;
                clr0_w = 1'b0;
            end
            2'b00:
            begin
                clr1_w = 1'b0;
                clr0_w = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Action register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
            sensor_irq_motor_action_reg <= `SIMA_ACT_RESET;
        else if (bus_in.wr && bus_in.addr == `SIMA_ACT_OFFSET)
            sensor_irq_motor_action_reg <=
                bus_in.wdata & `SIMA_ACT_WMASK;
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // New edges win over a status read so no event is lost
    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
            irq_status_reg <= `SIMA_STAT_RESET;
        else
        begin
            irq_status_reg <= ((stat_rd_w ? 4'h0 : irq_status_reg)
                & ~{2'b00, clr1_w, clr0_w}) | new_w;
        end
    end

    // ------------------------------------------------------------
    // Motor requests
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            stop_seen_reg <= 1'b0;
            run_last_reg <= 1'b0;
        end
        else
        begin
            run_last_reg <= motor_running_in;
            if (motor_running_in && !run_last_reg)
                stop_seen_reg <= 1'b0;
            else if ((act0_w || act1_w) && !code_w[2] && !code_w[0])
                stop_seen_reg <= 1'b1;
            else if ((act0_w || act1_w) && code_w == SIMA_ACT_STOP_O)
                stop_seen_reg <= 1'b1;
        end
    end

    // The outside sequencer runs overdrive, ramp-down and the loop pause
    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
            cmd_out <= '0;
        else
        begin
            cmd_out.stop_req <= (act0_w || act1_w) && !code_w[2]
                && code_w != SIMA_ACT_REV_E;
            cmd_out.reverse_req <= (act0_w || act1_w)
                && code_w == SIMA_ACT_REV_E;
            cmd_out.restart_req <= (act0_w || act1_w) && code_w[2]
                && !stop_seen_reg;
            cmd_out.overdrive_steps <= act0_w ? overdrive_count_zero_in
                : overdrive_count_one_in;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rdata_out <= 8'h00;
            irq_status_out <= 4'h0;
        end
        else
        begin
            irq_status_out <= irq_status_reg;
            if (bus_in.addr == `SIMA_ACT_OFFSET)
                rdata_out <= sensor_irq_motor_action_reg;
            else if (bus_in.addr == `SIMA_STAT_OFFSET)
                rdata_out <= {4'h0, irq_status_reg};
            else
                rdata_out <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_disabled_quiet;
        @(posedge sys_clk_in) disable iff (reset_in)
        !enable_w |=> !cmd_out.stop_req && !cmd_out.reverse_req
            && !cmd_out.restart_req;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("motor request while disabled");

    property p_ramp_quiet;
        @(posedge sys_clk_in) disable iff (reset_in)
        ramping_in |-> !act0_w && !act1_w;
    endproperty
    a_ramp_quiet: assert property (p_ramp_quiet)
        else $error("action during ramp");

    property p_latch;
        @(posedge sys_clk_in) disable iff (reset_in)
        new_w[0] |=> irq_status_reg[0];
    endproperty
    a_latch: assert property (p_latch)
        else $error("edge not latched");

    property p_rsvd;
        @(posedge sys_clk_in) disable iff (reset_in)
        sensor_irq_motor_action_reg[2:1] == 2'b00;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits set");

    property p_rev;
        @(posedge sys_clk_in) disable iff (reset_in)
        act0_w && code_w == SIMA_ACT_REV_E |=> cmd_out.reverse_req;
    endproperty
    a_rev: assert property (p_rev)
        else $error("reverse missing");

    property p_upper;
        @(posedge sys_clk_in) disable iff (reset_in)
        new_w[3:2] != 2'b00 && new_w[1:0] == 2'b00 |=> !cmd_out.stop_req;
    endproperty
    a_upper: assert property (p_upper)
        else $error("upper input acted");

    property p_prio;
        @(posedge sys_clk_in) disable iff (reset_in)
        act0_w |-> !act1_w;
    endproperty
    a_prio: assert property (p_prio)
        else $error("both inputs acted");

    property p_stopped;
        @(posedge sys_clk_in) disable iff (reset_in)
        !motor_running_in |=> !cmd_out.stop_req && !cmd_out.restart_req;
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("action while stopped");

    property p_autoclr;
        @(posedge sys_clk_in) disable iff (reset_in)
        clr0_w && !new_w[0] && !stat_rd_w |=> !irq_status_reg[0];
    endproperty
    a_autoclr: assert property (p_autoclr)
        else $error("partner did not clear flag");

    property p_restart_drop;
        @(posedge sys_clk_in) disable iff (reset_in)
        stop_seen_reg |=> !cmd_out.restart_req;
    endproperty
    a_restart_drop: assert property (p_restart_drop)
        else $error("restart after stop");
endmodule

// ==== verif/sima_sensors.sv ====
/*
 * Position sensor model: each request bit gives a four-cycle high
 * pulse on that pin. Assumes requests change just after a clock edge.
 */
`timescale 1ns/1ps

module sima_sensors
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic [3:0] pulse_in,
    output logic [3:0] pin_out
);
    logic [2:0] left_reg [4];

    // Idle level is low, so a rising edge marks the sensor hit
    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (reset_in)
                left_reg[i] <= 3'h0;
            else if (pulse_in[i])
                left_reg[i] <= 3'h4;
            else if (left_reg[i] != 3'h0)
                left_reg[i] <= left_reg[i] - 3'h1;
        end
    end

    always_comb
    begin
        for (int i = 0; i < 4; i++)
            pin_out[i] = (left_reg[i] != 3'h0);
    end
endmodule

// ==== verif/tb.sv ====
/*
 * Self-checking bench of the sensor interrupt motor action core.
 * Assumes the package and header on the include path; edge select and
 * mask are driven by the bench, rising edges and unmasked by default.
 */
`timescale 1ns/1ps

module tb
    import sima_pkg::*;
;
    logic sys_clk = 0;
    logic reset = 1;
    sima_bus_t bus = '0;
    logic [3:0] pulse = '0;
    logic [3:0] pins;
    logic run = 0;
    logic ramp = 0;
    logic [3:0] sel = '0;
    logic [3:0] msk = '0;
    logic [7:0] rdata;
    logic [7:0] rd_val;
    logic [3:0] stat;
    sima_cmd_t cmd;
    int n_stop, n_rev, n_rst, err_total, checked;
    logic [7:0] od_seen;

    sima_sensors sima_sensors_inst (.sys_clk_in(sys_clk),
        .reset_in(reset), .pulse_in(pulse), .pin_out(pins));
    sima_core sima_core_inst (.sys_clk_in(sys_clk), .reset_in(reset),
        .bus_in(bus), .sensor_pin_in(pins), .irq_edge_select_in(sel),
        .irq_mask_reg_in(msk), .motor_running_in(run),
        .ramping_in(ramp), .overdrive_count_zero_in(8'h5a),
        .overdrive_count_one_in(8'ha5), .rdata_out(rdata),
        .irq_status_out(stat), .cmd_out(cmd));

    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end

    // Request pulses last one cycle, so count them at every edge
    always @(posedge sys_clk)
    begin
        if (cmd.stop_req === 1'b1 || cmd.reverse_req === 1'b1)
            od_seen = cmd.overdrive_steps;
        n_stop += (cmd.stop_req === 1'b1);
        n_rev += (cmd.reverse_req === 1'b1);
        n_rst += (cmd.restart_req === 1'b1);
    end

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic bus_op(logic w, logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk);
        #5 bus = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk);
        #1 rd_val = rdata;
        #4 bus = '{wr: 1'b0, rd: 1'b0, addr: a, wdata: d};
    endtask

    // A falling then rising run level stands for a fresh motor start
    task automatic prep(logic [2:0] code, logic [1:0] clr, logic en);
        run = 0;
        bus_op(1, 8'h08, {code, clr, 2'b00, en});
        bus_op(0, 8'h06, 8'h00);
        run = 1;
        n_stop = 0;
        n_rev = 0;
        n_rst = 0;
        od_seen = 8'h00;
    endtask

    task automatic hit(logic [3:0] m);
        int n;
        @(posedge sys_clk);
        #5 pulse = m;
        @(posedge sys_clk);
        #5 pulse = '0;
        for (n = 0; n < 20 && (stat & m & ~msk) !== (m & ~msk); n++)
        begin
            @(posedge sys_clk);
            #5;
        end
        if (n == 20)
        begin
            check("flag wait", 8'h00, 8'h01);
            end_of_test();
        end
        repeat (6) @(posedge sys_clk);
        #5;
    endtask

    task automatic expect_cmd(int s, int r, int t, logic [3:0] st);
        check("stops", n_stop[7:0], s[7:0]);
        check("reverses", n_rev[7:0], r[7:0]);
        check("restarts", n_rst[7:0], t[7:0]);
        check("status", {4'h0, stat}, {4'h0, st});
    endtask

    task automatic t_regs();
        check("status after reset", {4'h0, stat}, 8'h00);
        bus_op(0, 8'h08, 8'h00);
        check("action reset", rd_val, 8'h00);
        bus_op(1, 8'h08, 8'hff);
        bus_op(0, 8'h08, 8'h00);
        check("reserved bits", rd_val, 8'hf9);
        bus_op(0, 8'h3c, 8'h00);
        check("unmapped read", rd_val, 8'h00);
    endtask

    task automatic t_codes();
        logic [2:0] c;
        logic stp, rv, rs;
        for (int k = 0; k < 16; k++)
        begin
            c = k[3:1];
            stp = c <= 3'd2 && (c == 3'd2 || c[0] == k[0]);
            rv = c == 3'd3;
            rs = c[2] && (c[1] || c[0] == k[0]);
            prep(c, 2'b00, 1);
            hit(4'h1 << k[0]);
            expect_cmd(stp, rv, rs, 4'h1 << k[0]);
            if (stp || rv)
                check("overdrive", od_seen, k[0] ? 8'ha5 : 8'h5a);
        end
    endtask

    task automatic t_guards();
        prep(3'd0, 2'b00, 0);
        hit(4'h1);
        expect_cmd(0, 0, 0, 4'h1);
        bus_op(0, 8'h06, 8'h00);
        check("status read", rd_val, 8'h01);
        // The status copy on the output lags the clear by one edge
        @(posedge sys_clk);
        #5;
        check("flags cleared", {4'h0, stat}, 8'h00);
        prep(3'd2, 2'b00, 1);
        hit(4'hc);
        expect_cmd(0, 0, 0, 4'hc);
        prep(3'd0, 2'b00, 1);
        ramp = 1;
        hit(4'h1);
        expect_cmd(0, 0, 0, 4'h1);
        prep(3'd0, 2'b00, 1);
        ramp = 0;
        @(posedge sys_clk);
        #5;
        run = 0;
        hit(4'h1);
        expect_cmd(0, 0, 0, 4'h1);
        prep(3'd0, 2'b00, 1);
        msk = 4'h1;
        hit(4'h1);
        expect_cmd(0, 0, 0, 4'h0);
        msk = 4'h0;
        sel = 4'h1;
        hit(4'h1);
        expect_cmd(1, 0, 0, 4'h1);
        sel = 4'h0;
        hit(4'h1);
        expect_cmd(1, 0, 0, 4'h1);
        bus_op(1, 8'h08, 8'h81);
        bus_op(0, 8'h06, 8'h00);
        hit(4'h1);
        expect_cmd(1, 0, 0, 4'h1);
    endtask

    task automatic t_autoclear();
        for (int k = 0; k < 4; k++)
        begin
            prep(3'd3, k[1:0], 1);
            hit(4'h2);
            hit(4'h1);
            expect_cmd(0, 2, 0, k[0] ? 4'h1 : 4'h3);
        end
        prep(3'd0, 2'b01, 1);
        hit(4'h2);
        hit(4'h1);
        expect_cmd(1, 0, 0, 4'h3);
        prep(3'd0, 2'b01, 1);
        hit(4'h1);
        hit(4'h2);
        expect_cmd(1, 0, 0, 4'h2);
        prep(3'd2, 2'b00, 1);
        hit(4'h3);
        expect_cmd(1, 0, 0, 4'h3);
        check("simultaneous overdrive", od_seen, 8'h5a);
    endtask

    initial
    begin
        repeat (16) @(posedge sys_clk);
        #5 reset = 0;
        t_regs();
        t_codes();
        t_guards();
        t_autoclear();
        end_of_test();
    end
endmodule
